// File: hsr_consts.vh
`ifndef HSR_CONSTS_VH
`define HSR_CONSTS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define HSR_CLK_HZ 20000000
`define HSR_BOOT_MS 1000
`define HSR_WDOG_MS 500
`define HSR_BOOT_CYC (`HSR_BOOT_MS * (`HSR_CLK_HZ / 1000))
`define HSR_WDOG_CYC (`HSR_WDOG_MS * (`HSR_CLK_HZ / 1000))

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define HSR_OFF_CTRL 8'h00
`define HSR_OFF_STATUS 8'h04
`define HSR_OFF_TXDATA 8'h08
`define HSR_OFF_RXDATA 8'h0c

// ----------------------------------------
// control fields
// ----------------------------------------
`define HSR_CTRL_DRIVE 0
`define HSR_CTRL_KICK 1

// ----------------------------------------
// status fields
// ----------------------------------------
`define HSR_ST_RUN 0
`define HSR_ST_BOOT 1
`define HSR_ST_LOAD 2
`define HSR_ST_ARMED 3
`define HSR_ST_WDFIRED 4
`define HSR_ST_RXAVAIL 5
`define HSR_ST_CSACT 6
`define HSR_ST_TXGATE 7

// ----------------------------------------
// reset values and responses
// ----------------------------------------
`define HSR_TX_RST 8'h00
// gate, arm, load, restart, mosi, cs, sclk: idle levels of the pulled pins
`define HSR_PIN_RST 7'h6a
`define HSR_RESP_OKAY 2'h0
`define HSR_RESP_SLVERR 2'h2

`endif

// File: hsr_sync.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// three-stage pin synchroniser
// ----------------------------------------
module hsr_sync #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// clock and reset
	input wire clk,
	input wire srst,
	// pins and result
	input wire [W-1:0] pin,
	output wire [W-1:0] val
);

reg [W-1:0] s1_r;
reg [W-1:0] s2_r;
reg [W-1:0] s3_r;
reg [W-1:0] held_r;

// a bit counts only once stages two and three agree
wire [W-1:0] agree = ~(s2_r ^ s3_r);

assign val = (agree & s3_r) | (~agree & held_r);

always @(posedge clk) begin
	if (srst) begin
		s1_r <= RST_VAL;
		s2_r <= RST_VAL;
		s3_r <= RST_VAL;
		held_r <= RST_VAL;
	end else begin
		s1_r <= pin;
		s2_r <= s1_r;
		s3_r <= s2_r;
		held_r <= val;
	end
end

endmodule // hsr_sync

`default_nettype wire

// File: hsr_ctrl.v
// Summary of operation
// - device is a serial slave only; master clocks between 50 kHz and 4 MHz.
// - mode 0: sample on rising serial clock, change data on falling edge.
// - device talks only while the master holds its low-active select low.
// - serial data output stays released whenever no transfer is in progress.
// - addresses, commands and data arrive on the serial data input.
// - shared clock and data lines; each slave gets its own select.
// - while hard restart input is low the core stays in reset; EEPROM route and bus stay live.
// - after restart release the device boots, then starts adapting.
// - load select low: normal; high: serial port routed to EEPROM.
// - undriven load select reads low, giving normal operation.
// - watchdog reboots on firmware hang; its enable floats high.
// - status indication is an open-drain output, high when released.
`timescale 1ns/1ps
`default_nettype none
`include "hsr_consts.vh"

module hsr_ctrl #(
	parameter [31:0] BOOT_CYCLES = `HSR_BOOT_CYC,
	parameter [31:0] WDOG_CYCLES = `HSR_WDOG_CYC
) (
	// clock and reset
	input wire clk,
	input wire srst,
	// axi4-lite write
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// control pins
	input wire hard_restart_low,
	input wire watchdog_arm_in,
	input wire eeprom_load_sel,
	input wire tx_gate_in,
	output wire status_flag_out_o,
	output wire status_flag_out_oe_n,
	// serial port pins
	input wire sclk,
	input wire chip_sel_n,
	input wire serial_in,
	output wire serial_out_o,
	output wire serial_out_oe_n,
	// internal eeprom port
	output reg ee_cs_n,
	output reg ee_sclk,
	output reg ee_mosi,
	input wire ee_miso,
	// core state
	output wire fw_running
);

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
wire [6:0] pins_s;
wire pin_sclk = pins_s[0];
wire pin_cs_n = pins_s[1];
wire pin_mosi = pins_s[2];
wire pin_restart_n = pins_s[3];
wire pin_load = pins_s[4];
wire pin_arm = pins_s[5];
wire pin_gate = pins_s[6];

hsr_sync #(
	.W(7),
	.RST_VAL(`HSR_PIN_RST)
) u_sync (
	.clk(clk),
	.srst(srst),
	.pin({tx_gate_in, watchdog_arm_in, eeprom_load_sel, hard_restart_low,
		serial_in, chip_sel_n, sclk}),
	.val(pins_s)
);

wire core_rst = srst | ~pin_restart_n;

// ----------------------------------------
// axi4-lite slave
// ----------------------------------------
reg aw_v_r;
reg [7:0] aw_a_r;
reg w_v_r;
reg [31:0] w_d_r;
reg [3:0] w_s_r;

assign s_axi_awready = ~aw_v_r & ~s_axi_bvalid;
assign s_axi_wready = ~w_v_r & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

wire wr_fire = aw_v_r & w_v_r & ~s_axi_bvalid;
wire [7:0] wr_addr = {aw_a_r[7:2], 2'b00};
wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
wire rd_fire = s_axi_arvalid & ~s_axi_rvalid;
wire wr_ok = (wr_addr == `HSR_OFF_CTRL) | (wr_addr == `HSR_OFF_STATUS) |
	(wr_addr == `HSR_OFF_TXDATA) | (wr_addr == `HSR_OFF_RXDATA);
wire wr_lane0 = wr_fire & w_s_r[0];
wire wr_ctrl = wr_lane0 & (wr_addr == `HSR_OFF_CTRL);
wire wr_stat = wr_lane0 & (wr_addr == `HSR_OFF_STATUS);
wire wr_tx = wr_lane0 & (wr_addr == `HSR_OFF_TXDATA);
wire rd_rx = rd_fire & (rd_addr == `HSR_OFF_RXDATA);

// address and data may arrive in either order
always @(posedge clk) begin
	if (srst) begin
		aw_v_r <= 1'b0;
		aw_a_r <= 8'h00;
		w_v_r <= 1'b0;
		w_d_r <= 32'h0000_0000;
		w_s_r <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `HSR_RESP_OKAY;
	end else begin
		if (s_axi_awvalid & s_axi_awready) begin
			aw_v_r <= 1'b1;
			aw_a_r <= s_axi_awaddr;
		end
		if (s_axi_wvalid & s_axi_wready) begin
			w_v_r <= 1'b1;
			w_d_r <= s_axi_wdata;
			w_s_r <= s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_v_r <= 1'b0;
			w_v_r <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `HSR_RESP_OKAY : `HSR_RESP_SLVERR;
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// ----------------------------------------
// serial slave engine
// ----------------------------------------
reg sclk_d_r;
reg sel_d_r;
reg [2:0] bitcnt_r;
reg [7:0] rx_sh_r;
reg [7:0] rx_data_r;
reg rx_avail_r;
reg [7:0] tx_sh_r;
reg [7:0] tx_reg_r;

wire spi_on = ~pin_cs_n & ~pin_load;
wire spi_start = spi_on & ~sel_d_r;
wire sclk_rise = pin_sclk & ~sclk_d_r;
wire sclk_fall = ~pin_sclk & sclk_d_r;
wire byte_done = spi_on & ~spi_start & sclk_rise & (bitcnt_r == 3'h7);
wire next_bit = (bitcnt_r == 3'h0) ? tx_reg_r[7] : tx_sh_r[6];
// look ahead one bit so output follows the falling edge a cycle sooner
wire spi_dout = (spi_on & sclk_fall) ? next_bit : tx_sh_r[7];

always @(posedge clk) begin
	if (core_rst) begin
		sclk_d_r <= 1'b0;
		sel_d_r <= 1'b0;
		bitcnt_r <= 3'h0;
		rx_sh_r <= 8'h00;
		rx_data_r <= 8'h00;
		tx_sh_r <= `HSR_TX_RST;
	end else begin
		sclk_d_r <= pin_sclk;
		sel_d_r <= spi_on;
		if (!spi_on) begin
			bitcnt_r <= 3'h0;
		end else if (spi_start) begin
			bitcnt_r <= 3'h0;
			tx_sh_r <= tx_reg_r;
		end else begin
			if (sclk_rise) begin
				rx_sh_r <= {rx_sh_r[6:0], pin_mosi};
				bitcnt_r <= bitcnt_r + 3'h1;
				if (bitcnt_r == 3'h7) begin
					rx_data_r <= {rx_sh_r[6:0], pin_mosi};
				end
			end
			if (sclk_fall) begin
				if (bitcnt_r == 3'h0) begin
					tx_sh_r <= tx_reg_r;
				end else begin
					tx_sh_r <= {tx_sh_r[6:0], 1'b0};
				end
			end
		end
	end
end

// received byte flag: a new byte beats a read clear
always @(posedge clk) begin
	if (core_rst) begin
		rx_avail_r <= 1'b0;
	end else begin
		rx_avail_r <= byte_done | (rx_avail_r & ~rd_rx);
	end
end

// ----------------------------------------
// eeprom route
// ----------------------------------------
// not tied to the restart pin: programming runs with the core held in reset
always @(posedge clk) begin
	if (srst) begin
		ee_cs_n <= 1'b1;
		ee_sclk <= 1'b0;
		ee_mosi <= 1'b0;
	end else if (pin_load) begin
		ee_cs_n <= pin_cs_n;
		ee_sclk <= pin_sclk;
		ee_mosi <= pin_mosi;
	end else begin
		ee_cs_n <= 1'b1;
		ee_sclk <= 1'b0;
		ee_mosi <= 1'b0;
	end
end

wire dout_en = ~pin_cs_n & (pin_load | ~core_rst);
assign serial_out_oe_n = ~dout_en;
assign serial_out_o = pin_load ? ee_miso : spi_dout;

// ----------------------------------------
// boot sequence and watchdog
// ----------------------------------------
localparam ST_BOOT = 1'b0;
localparam ST_RUN = 1'b1;

reg state_r;
reg [31:0] boot_cnt_r;
reg [31:0] wd_cnt_r;
reg wd_fired_r;
reg drive_r;

wire wd_kick = wr_ctrl & w_d_r[`HSR_CTRL_KICK];
wire wd_expire = (state_r == ST_RUN) & pin_arm & ~wd_kick &
	(wd_cnt_r == WDOG_CYCLES - 32'h1);

always @(posedge clk) begin
	if (core_rst) begin
		state_r <= ST_BOOT;
		boot_cnt_r <= 32'h0000_0000;
		wd_cnt_r <= 32'h0000_0000;
	end else begin
		case (state_r)
			ST_BOOT: begin
				wd_cnt_r <= 32'h0000_0000;
				if (boot_cnt_r == BOOT_CYCLES - 32'h1) begin
					boot_cnt_r <= 32'h0000_0000;
					state_r <= ST_RUN;
				end else begin
					boot_cnt_r <= boot_cnt_r + 32'h1;
				end
			end
			ST_RUN: begin
				if (wd_expire) begin
					wd_cnt_r <= 32'h0000_0000;
					state_r <= ST_BOOT;
				end else if (!pin_arm || wd_kick) begin
					wd_cnt_r <= 32'h0000_0000;
				end else begin
					wd_cnt_r <= wd_cnt_r + 32'h1;
				end
			end
			default: begin
				state_r <= ST_BOOT;
				boot_cnt_r <= 32'h0000_0000;
				wd_cnt_r <= 32'h0000_0000;
			end
		endcase
	end
end

assign fw_running = (state_r == ST_RUN);

// software registers; expiry beats a clear in the same cycle
always @(posedge clk) begin
	if (core_rst) begin
		wd_fired_r <= 1'b0;
		drive_r <= 1'b0;
		tx_reg_r <= `HSR_TX_RST;
	end else begin
		wd_fired_r <= wd_expire |
			(wd_fired_r & ~(wr_stat & w_d_r[`HSR_ST_WDFIRED]));
		if (wr_ctrl) begin
			drive_r <= w_d_r[`HSR_CTRL_DRIVE];
		end
		if (wr_tx) begin
			tx_reg_r <= w_d_r[7:0];
		end
	end
end

assign status_flag_out_o = 1'b0;
assign status_flag_out_oe_n = ~drive_r;

// ----------------------------------------
// read path
// ----------------------------------------
reg [31:0] rd_val;
reg rd_ok;

always @* begin
	rd_val = 32'h0000_0000;
	rd_ok = 1'b1;
	case (rd_addr)
		`HSR_OFF_CTRL: begin
			rd_val[`HSR_CTRL_DRIVE] = drive_r;
		end
		`HSR_OFF_STATUS: begin
			rd_val[`HSR_ST_RUN] = fw_running;
			rd_val[`HSR_ST_BOOT] = ~core_rst & ~fw_running;
			rd_val[`HSR_ST_LOAD] = pin_load;
			rd_val[`HSR_ST_ARMED] = pin_arm;
			rd_val[`HSR_ST_WDFIRED] = wd_fired_r;
			rd_val[`HSR_ST_RXAVAIL] = rx_avail_r;
			rd_val[`HSR_ST_CSACT] = ~pin_cs_n;
			rd_val[`HSR_ST_TXGATE] = pin_gate;
		end
		`HSR_OFF_TXDATA: begin
			rd_val[7:0] = tx_reg_r;
		end
		`HSR_OFF_RXDATA: begin
			rd_val[7:0] = rx_data_r;
		end
		default: begin
			rd_ok = 1'b0;
		end
	endcase
end

always @(posedge clk) begin
	if (srst) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `HSR_RESP_OKAY;
	end else if (rd_fire) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rdata <= rd_val;
		s_axi_rresp <= rd_ok ? `HSR_RESP_OKAY : `HSR_RESP_SLVERR;
	end else if (s_axi_rvalid & s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

endmodule // hsr_ctrl

`default_nettype wire

// File: hsr_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module hsr_props #(
	parameter [31:0] BOOT_CYCLES = 32'h14
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// pins
	input wire logic hard_restart_low,
	input wire logic eeprom_load_sel,
	input wire logic sclk,
	input wire logic chip_sel_n,
	input wire logic status_flag_out_o,
	input wire logic serial_out_oe_n,
	input wire logic ee_cs_n,
	input wire logic ee_sclk,
	input wire logic fw_running
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// cycles since restart pin went high
	logic [31:0] up_cnt_r;
	always_ff @(posedge clk) begin
		if (srst || !hard_restart_low)
			up_cnt_r <= 32'h0;
		else if (up_cnt_r != 32'hffffffff)
			up_cnt_r <= up_cnt_r + 32'h1;
	end
	chk_oe_idle: assert property (chip_sel_n [*6] |-> serial_out_oe_n)
		else $error("serial out driven while idle");
	chk_oe_active: assert property ((!chip_sel_n && hard_restart_low && !eeprom_load_sel) [*6]
		|-> !serial_out_oe_n) else $error("serial out not driven while selected");
	chk_restart_hold: assert property (!hard_restart_low [*6] |-> !fw_running)
		else $error("running while restart held");
	chk_boot_time: assert property ($rose(fw_running) |-> up_cnt_r >= BOOT_CYCLES)
		else $error("boot finished early");
	chk_ee_route: assert property ((eeprom_load_sel && $stable(sclk)) [*8] |-> ee_sclk == sclk)
		else $error("eeprom clock not routed");
	chk_ee_idle: assert property (!eeprom_load_sel [*8] |-> ee_cs_n && !ee_sclk)
		else $error("eeprom port active in normal mode");
	chk_status_od: assert property (status_flag_out_o == 1'b0)
		else $error("status pin driven high");
	chk_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write answer late");
	chk_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	cov_boot: cover property ($rose(fw_running));
	cov_load: cover property (eeprom_load_sel && !ee_cs_n);
	cov_frame: cover property (!serial_out_oe_n ##1 serial_out_oe_n);
endmodule // hsr_props
bind hsr_ctrl hsr_props #(.BOOT_CYCLES(BOOT_CYCLES)) u_props (.clk, .srst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .hard_restart_low, .eeprom_load_sel, .sclk, .chip_sel_n,
	.status_flag_out_o, .serial_out_oe_n, .ee_cs_n, .ee_sclk, .fw_running);
`default_nettype wire

// File: hsr_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// serial bus master model
// ----------------------------------------
module hsr_spi_host (
	// serial pins
	output logic sclk,
	output logic chip_sel_n,
	output logic serial_in,
	input wire logic miso
);
	// 400 ns link period, even duty
	localparam int HALF = 200;
	initial begin
		sclk = 1'b0;
		chip_sel_n = 1'b1;
		serial_in = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		logic [7:0] t;
		begin
			t = tx;
			rx = 8'h00;
			chip_sel_n = 1'b0;
			serial_in = t[7];
			// select setup with margin for the pin synchronisers
			#(2 * HALF);
			for (int i = 0; i < nb; i++) begin
				sclk = 1'b1;
				rx = {rx[6:0], miso};
				#HALF;
				sclk = 1'b0;
				t = {t[6:0], 1'b0};
				serial_in = t[7];
				#HALF;
			end
			// clock stands still, data to pull-down level
			chip_sel_n = 1'b1;
			serial_in = 1'b0;
			#(2 * HALF);
		end
	endtask
endmodule // hsr_spi_host
`default_nettype wire

// File: hsr_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsr_consts.vh"
module hsr_ctrl_tb_top;
	localparam int BOOT = 20;
	localparam int WDOG = 40;
	logic clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rx;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic hard_restart_low, watchdog_arm_in, eeprom_load_sel, tx_gate_in, status_flag_out_o;
	logic status_flag_out_oe_n, sclk, chip_sel_n, serial_in, serial_out_o, serial_out_oe_n;
	logic ee_cs_n, ee_sclk, ee_mosi, ee_miso, fw_running;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	// pulled-up lines
	wire so_line = serial_out_oe_n ? 1'b1 : serial_out_o;
	wire stat_line = status_flag_out_oe_n ? 1'b1 : status_flag_out_o;
	hsr_ctrl #(.BOOT_CYCLES(32'h14), .WDOG_CYCLES(32'h28)) dut (.clk, .srst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hard_restart_low,
		.watchdog_arm_in, .eeprom_load_sel, .tx_gate_in, .status_flag_out_o, .status_flag_out_oe_n,
		.sclk, .chip_sel_n, .serial_in, .serial_out_o, .serial_out_oe_n, .ee_cs_n, .ee_sclk,
		.ee_mosi, .ee_miso, .fw_running);
	hsr_spi_host host (.sclk, .chip_sel_n, .serial_in, .miso(so_line));
	// 20 MHz reference, no eeprom setup needed
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		cmp("bresp", er, s_axi_bresp);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		cmp("rresp", er, s_axi_rresp);
		cmp("rdata", ed, s_axi_rdata);
	endtask
	task automatic wait_run(input logic lvl, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (fw_running !== lvl && n < 500);
	endtask
	task automatic t_regs;
		axi_wr(`HSR_OFF_TXDATA, 32'ha5, 4'hf, `HSR_RESP_OKAY);
		axi_wr(`HSR_OFF_TXDATA, 32'h11, 4'h0, `HSR_RESP_OKAY);
		axi_rd(`HSR_OFF_TXDATA, 32'ha5, `HSR_RESP_OKAY);
		axi_wr(8'h10, 32'h1, 4'hf, `HSR_RESP_SLVERR);
		axi_rd(8'h10, 32'h0, `HSR_RESP_SLVERR);
		axi_wr(`HSR_OFF_CTRL, 32'h1, 4'hf, `HSR_RESP_OKAY);
		cmp("status_pin", 1'b0, stat_line);
		axi_wr(`HSR_OFF_CTRL, 32'h0, 4'hf, `HSR_RESP_OKAY);
		cmp("status_pin", 1'b1, stat_line);
		$display("test regs done");
	endtask
	task automatic t_boot;
		int n;
		@(posedge clk);
		// restart pulse longer than 1 us
		hard_restart_low <= 1'b0;
		repeat (24) @(posedge clk);
		cmp("fw_running", 1'b0, fw_running);
		axi_rd(`HSR_OFF_TXDATA, `HSR_TX_RST, `HSR_RESP_OKAY);
		hard_restart_low <= 1'b1;
		wait_run(1'b1, n);
		cmp("boot_len", 1'b1, n >= BOOT && n < BOOT + 10);
		wait_run(1'b0, n);
		cmp("wdog_len", 1'b1, n >= WDOG && n < WDOG + 10);
		axi_rd(`HSR_OFF_STATUS, 32'h9a, `HSR_RESP_OKAY);
		cmp("wd_fired", 1'b1, s_axi_rdata[`HSR_ST_WDFIRED]);
		watchdog_arm_in <= 1'b0;
		wait_run(1'b1, n);
		$display("test boot done");
	endtask
	task automatic t_spi;
		axi_wr(`HSR_OFF_TXDATA, 32'h3c, 4'h1, `HSR_RESP_OKAY);
		host.xfer(8'h96, 8, rx);
		cmp("spi_rx", 8'h3c, rx);
		axi_rd(`HSR_OFF_STATUS, 32'hb1, `HSR_RESP_OKAY);
		axi_rd(`HSR_OFF_RXDATA, 32'h96, `HSR_RESP_OKAY);
		host.xfer(8'hff, 3, rx);
		host.xfer(8'h5a, 8, rx);
		axi_rd(`HSR_OFF_RXDATA, 32'h5a, `HSR_RESP_OKAY);
		$display("test spi done");
	endtask
	task automatic t_load;
		int n;
		@(posedge clk);
		// load high, core held in reset
		eeprom_load_sel <= 1'b1;
		hard_restart_low <= 1'b0;
		for (int v = 0; v < 2; v++) begin
			ee_miso <= v[0];
			fork
				host.xfer(8'hc3, 8, rx);
				begin
					repeat (8) @(posedge clk);
					cmp("ee_cs_n", 1'b0, ee_cs_n);
				end
			join
			cmp("ee_data", {8{v[0]}}, rx);
		end
		eeprom_load_sel <= 1'b0;
		repeat (20) @(posedge clk);
		hard_restart_low <= 1'b1;
		wait_run(1'b1, n);
		cmp("reboot", 1'b1, fw_running);
		$display("test load done");
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		{hard_restart_low, watchdog_arm_in, eeprom_load_sel, tx_gate_in, ee_miso} = 5'h1a;
		srst = 1'b1;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_boot();
		t_spi();
		t_load();
		test_done();
	end
	initial begin
		forever begin
			@(posedge clk);
			cyc++;
			if (cyc > 40000) begin
				n_errors++;
				test_done();
			end
		end
	end
endmodule // hsr_ctrl_tb_top
`default_nettype wire
